// *** logic/sotp_prog_port.v ***
/*
 * Programming-mode serial port of a one-time-programmable serial memory:
 * mode entry, bit shifter, word counter, programming strobe and the
 * cascade/polarity output.
 * Assumes all pins are synchronous to core_clk; supply levels arrive as
 * decoded comparator flags.
 */
// Contract
// - One data bit moves through the data pin per serial clock rising edge.
// - Both enables high: shift one data pin bit into the word latch.
// - Select low, output enable high: drive next stored bit for verify.
// - Select high, output enable low: advance the word counter by one.
// - In programming mode the reset pin is only the active-high enable.
// - Cascade output shows programmed reset polarity on programming entry.
// - Cascade output drops low one clock after the last array bit out.
// - Polarity word at max address plus one; zeros low, default high.
`timescale 1ns/1ps
`include "sotp_regs.vh"

module sotp_prog_port (
  input wire core_clk, // System clock, 200 MHz
  input wire nrst, // Synchronous reset, active low
  input wire serial_clk, // Programmer serial clock
  input wire chip_select_n, // Chip enable, active low
  input wire reset_or_enable_pin, // Output enable in programming mode
  input wire vpp_high, // Supply at program_level_high
  input wire vpp_entry, // Supply at mode_entry_level
  input wire data_in, // Data pin input level
  output reg data_out_q, // Data pin output level
  output reg data_oe_q, // Data pin output enable, high drives
  output reg cascade_select_out_n_q, // Cascade output, active low
  output reg prog_mode_q, // Programming mode active
  output reg pgm_fault_q // Strobe outside its allowed width
);

  // ****************************************************************
  // Mode states
  // ****************************************************************
  localparam ST_IDLE = 4'b0001;
  localparam ST_HIGH = 4'b0010;
  localparam ST_ENTRY = 4'b0100;
  localparam ST_PROG = 4'b1000;

  reg [3:0] state_q;
  reg [1:0] hi_cnt_q;
  reg [`SOTP_WORD_W-1:0] mem [0:`SOTP_DEPTH-1];
  reg [`SOTP_WORD_W-1:0] latch_q;
  reg [`SOTP_BIT_W-1:0] bit_q;
  reg [`SOTP_ADDR_W:0] addr_q;
  reg [31:0] pgm_cnt_q;
  reg pgm_arm_q;
  reg end_seen_q;
  reg end_low_q;
  reg pol_high_q;
  integer k;
  wire clk_rise;
  wire oe_n;
  wire shift_in;
  wire shift_out;
  wire count_up;
  wire strobe;
  wire [`SOTP_WORD_W-1:0] cur_word;

  sotp_edge u_edge (
    .core_clk(core_clk),
    .nrst(nrst),
    .level_in(serial_clk),
    .rise_q(clk_rise)
  );

  // Polarity bits are ignored here on purpose
  assign oe_n = reset_or_enable_pin;
  assign shift_in = clk_rise & chip_select_n & oe_n;
  assign shift_out = clk_rise & ~chip_select_n & oe_n;
  assign count_up = clk_rise & chip_select_n & ~oe_n;
  assign strobe = vpp_high & (state_q == ST_PROG);
  assign cur_word = mem[addr_q];

  // Unprogrammed cells read as all ones; the array itself has no reset
  initial begin
    for (k = 0; k < `SOTP_DEPTH; k = k + 1) begin
      mem[k] = `SOTP_ERASED;
    end
  end

  function is_last_bit;
    input [`SOTP_ADDR_W:0] a;
    input [`SOTP_BIT_W-1:0] b;
    begin
      is_last_bit = (a == {1'b0, `SOTP_LAST_ADDR}) &&
        (b == `SOTP_BIT_LAST);
    end
  endfunction

  // ****************************************************************
  // Programming-mode entry
  // ****************************************************************
  always @(posedge core_clk) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      hi_cnt_q <= 2'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          hi_cnt_q <= 2'h0;
          if (clk_rise && vpp_high && chip_select_n && oe_n) begin
            hi_cnt_q <= 2'h1;
            state_q <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (clk_rise) begin
            if (!(chip_select_n && oe_n)) begin
              state_q <= ST_IDLE;
            end else if (vpp_high) begin
              // Saturate so a long high phase cannot wrap and refuse entry
              if (hi_cnt_q != `SOTP_ENTRY_HI_EDGES) begin
                hi_cnt_q <= hi_cnt_q + 2'h1;
              end
            end else if (vpp_entry &&
                hi_cnt_q >= `SOTP_ENTRY_HI_EDGES) begin
              state_q <= ST_PROG;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_ENTRY: begin
          state_q <= ST_PROG;
        end
        ST_PROG: begin
          // Leaving needs a power cycle, i.e. nrst
          state_q <= ST_PROG;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Shifter, counter and strobe
  // ****************************************************************
  // Array contents survive reset: the cells are nonvolatile
  always @(posedge core_clk) begin
    if (strobe && pgm_arm_q && pgm_cnt_q == 32'h0) begin
      mem[addr_q] <= latch_q;
    end
  end

  always @(posedge core_clk) begin
    if (!nrst) begin
      latch_q <= `SOTP_ERASED;
      bit_q <= {`SOTP_BIT_W{1'b0}};
      addr_q <= {(`SOTP_ADDR_W+1){1'b0}};
      pgm_cnt_q <= 32'h0;
      pgm_arm_q <= 1'b0;
      end_seen_q <= 1'b0;
      end_low_q <= 1'b0;
      pol_high_q <= 1'b1;
      data_out_q <= 1'b0;
      data_oe_q <= 1'b0;
      cascade_select_out_n_q <= 1'b1;
      prog_mode_q <= 1'b0;
      pgm_fault_q <= 1'b0;
    end else begin
      prog_mode_q <= (state_q == ST_PROG);
      if (state_q == ST_PROG) begin
        if (shift_in) begin
          latch_q <= {latch_q[`SOTP_WORD_W-2:0], data_in};
          bit_q <= bit_q + 1'b1;
          if (bit_q == `SOTP_BIT_LAST) begin
            pgm_arm_q <= 1'b1;
          end
        end
        if (shift_out) begin
          if (end_seen_q) begin
            // The rise after the last bit hands over to the cascade
            end_low_q <= 1'b1;
          end else begin
            data_out_q <= cur_word[`SOTP_BIT_LAST - bit_q];
            bit_q <= bit_q + 1'b1;
            if (is_last_bit(addr_q, bit_q)) begin
              end_seen_q <= 1'b1;
            end else if (bit_q == `SOTP_BIT_LAST) begin
              addr_q <= addr_q + 1'b1;
            end
          end
        end
        // The last bit stands until the cascade output takes over
        data_oe_q <= ~chip_select_n & oe_n & ~end_low_q;
        if (count_up) begin
          addr_q <= addr_q + 1'b1;
          bit_q <= {`SOTP_BIT_W{1'b0}};
        end
        // The word is written at the strobe's start, so its width can
        // only be judged afterwards: a bad width is flagged, not undone
        if (strobe) begin
          pgm_cnt_q <= pgm_cnt_q + 32'h1;
        end else if (pgm_cnt_q != 32'h0) begin
          pgm_cnt_q <= 32'h0;
          // A word completed in this very cycle keeps its arm
          if (!(shift_in && bit_q == `SOTP_BIT_LAST)) begin
            pgm_arm_q <= 1'b0;
          end
          if (pgm_cnt_q < `SOTP_PGM_MIN_CYC ||
              pgm_cnt_q > `SOTP_PGM_MAX_CYC) begin
            pgm_fault_q <= 1'b1;
          end
          if (addr_q == `SOTP_OVF_ADDR) begin
            pol_high_q <= (latch_q != `SOTP_POL_LOW);
          end
        end
        if (end_low_q) begin
          cascade_select_out_n_q <= 1'b0;
        end else begin
          cascade_select_out_n_q <= pol_high_q;
        end
      end else begin
        data_oe_q <= 1'b0;
        pol_high_q <= (mem[`SOTP_OVF_ADDR] != `SOTP_POL_LOW);
        cascade_select_out_n_q <= pol_high_q;
      end
    end
  end

endmodule // sotp_prog_port

// *** logic/sotp_regs.vh ***
/*
 * Constants for the serial one-time-programmable program port.
 * Assumes plain Verilog-2005 inclusion by bare name.
 */
`ifndef SOTP_REGS_VH
`define SOTP_REGS_VH

`define SOTP_WORD_W 32
`define SOTP_BIT_W 5
`define SOTP_ADDR_W 12
`define SOTP_DEPTH 4097
`define SOTP_LAST_ADDR 12'hfff
`define SOTP_OVF_ADDR 13'h1000
`define SOTP_POL_LOW 32'h00000000
`define SOTP_POL_HIGH 32'hffffffff
`define SOTP_ERASED 32'hffffffff
`define SOTP_BIT_LAST 5'h1f
`define SOTP_CLK_PERIOD_PS 5000
`define SOTP_PGM_MIN_PS 500000000
`define SOTP_PGM_MAX_PS 1050000000
`define SOTP_PGM_MIN_CYC (`SOTP_PGM_MIN_PS / `SOTP_CLK_PERIOD_PS)
`define SOTP_PGM_MAX_CYC (`SOTP_PGM_MAX_PS / `SOTP_CLK_PERIOD_PS)
`define SOTP_ENTRY_HI_EDGES 2'h2

`endif

// *** logic/sotp_edge.v ***
/*
 * Rising-edge detector for the programmer's serial clock.
 * Assumes the serial clock is already synchronous to core_clk.
 */
`timescale 1ns/1ps

module sotp_edge (
  input wire core_clk, // System clock
  input wire nrst, // Synchronous reset, active low
  input wire level_in, // Sampled level
  output reg rise_q // One-cycle pulse on a rising transition
);

  reg last_q;

  always @(posedge core_clk) begin
    if (!nrst) begin
      last_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      last_q <= level_in;
      rise_q <= level_in & ~last_q;
    end
  end

endmodule // sotp_edge

// *** test/sotp_prog_port_properties.sv ***
/* Checker for the program port pins.
   Assumes it is bound to sotp_prog_port. */
`timescale 1ns/1ps
module sotp_prog_port_props (
  input wire core_clk, // Clock
  input wire nrst, // Reset
  input wire serial_clk, // Serial clock
  input wire chip_select_n, // Select
  input wire reset_or_enable_pin, // Enable
  input wire vpp_entry, // Entry level
  input wire data_oe_q, // Pin enable
  input wire cascade_select_out_n_q, // Cascade
  input wire prog_mode_q, // Mode
  input wire pgm_fault_q // Fault
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_rise(c, o);
    prog_mode_q && $rose(serial_clk) && chip_select_n == c &&
      reset_or_enable_pin == o;
  endsequence
  a_reset_state: assert property (disable iff (1'b0) !nrst |=>
    !data_oe_q && cascade_select_out_n_q && !prog_mode_q && !pgm_fault_q)
    else $error("bad reset state");
  a_shift_quiet: assert property (s_rise(1, 1) |-> ##3 !data_oe_q)
    else $error("pin driven in shift");
  a_verify_drive: assert property (s_rise(0, 1) |->
    ##3 (data_oe_q || !cascade_select_out_n_q))
    else $error("pin idle in verify");
  a_count_quiet: assert property (s_rise(1, 0) |-> ##3 !data_oe_q)
    else $error("pin driven in count");
  a_locked_out: assert property ((!prog_mode_q)[*3] |-> !data_oe_q)
    else $error("pin driven outside mode");
  a_mode_entry: assert property ($rose(prog_mode_q) |->
    $past(vpp_entry, 2) && $past(chip_select_n, 2)) else $error("bad entry");
  a_mode_hold: assert property (prog_mode_q |=> prog_mode_q)
    else $error("mode dropped");
  a_fault_sticky: assert property (pgm_fault_q |=> pgm_fault_q)
    else $error("fault cleared");
endmodule // sotp_prog_port_props
bind sotp_prog_port sotp_prog_port_props i_props (.core_clk, .nrst,
  .serial_clk, .chip_select_n, .reset_or_enable_pin, .vpp_entry, .data_oe_q,
  .cascade_select_out_n_q, .prog_mode_q, .pgm_fault_q);

// *** test/sotp_programmer.sv ***
/* Programmer model: serial clock, enables, supply flags and data.
   Assumes one bench process calls its task at a clock edge. */
`timescale 1ns/1ps
module sotp_programmer (
  input wire core_clk, // Clock
  output reg serial_clk, // Serial clock
  output reg cs_n, // Select
  output reg oe_n, // Output enable
  output reg vph, // Supply high
  output reg vpe, // Supply entry
  output reg d, // Data
  output reg d_en // Drives data
);
  initial {serial_clk, cs_n, oe_n, vph, vpe, d, d_en} = 7'h0;
  // Levels settle two cycles before the rise, held two cycles after the fall
  task step(input logic [5:0] v, input logic p);
    begin
      {cs_n, oe_n, vph, vpe, d, d_en} <= v;
      repeat (2) @(posedge core_clk);
      serial_clk <= p;
      repeat (2) @(posedge core_clk);
      serial_clk <= 1'b0;
      repeat (2) @(posedge core_clk);
    end
  endtask
endmodule // sotp_programmer

// *** test/test_serial_otp_program_port.sv ***
/* Bench: entry table, then verify, program, count and end flag.
   Assumes the programmer model drives the pins; checker is bound. */
`timescale 1ns/1ps
`include "sotp_regs.vh"
module test_serial_otp_program_port;
  reg core_clk = 1'b0;
  reg nrst = 1'b0;
  wire sclk, cs_n, oe_n, vph, vpe, d, d_en, data_in;
  wire dout, doe, cso, pm, flt;
  integer n_errors = 0;
  integer n_compared = 0;
  integer i;
  logic [31:0] w;
  // Select, enable, high, entry levels, then mode after the rise
  logic [4:0] rows [0:2] = '{5'h1c, 5'h1c, 5'h1b};
  always #2.5 core_clk = ~core_clk;
  // No pull on the pin: undriven it shows the inverse level
  assign data_in = doe ? dout : d_en ? d : ~dout;
  sotp_programmer i_sotp_programmer (.core_clk, .serial_clk(sclk), .cs_n,
    .oe_n, .vph, .vpe, .d, .d_en);
  sotp_prog_port i_sotp_prog_port (.core_clk, .nrst, .serial_clk(sclk),
    .chip_select_n(cs_n), .reset_or_enable_pin(oe_n), .vpp_high(vph),
    .vpp_entry(vpe), .data_in, .data_out_q(dout), .data_oe_q(doe),
    .cascade_select_out_n_q(cso), .prog_mode_q(pm), .pgm_fault_q(flt));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task rd_word;
    begin
      for (i = 0; i < 32; i = i + 1) begin
        i_sotp_programmer.step(6'h10, 1'b1);
        w = {w[30:0], dout};
      end
    end
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    check({doe, cso, pm, flt}, 4'h4);
    nrst <= 1'b1;
    i_sotp_programmer.step(6'h10, 1'b1);
    check(doe, 1'b0);
    for (i = 0; i < 3; i = i + 1) begin
      i_sotp_programmer.step({rows[i][4:1], 2'h0}, 1'b1);
      check(pm, rows[i][0]);
    end
    check(cso, 1'b1);
    rd_word;
    check(w, `SOTP_ERASED);
    for (i = 0; i < 32; i = i + 1)
      i_sotp_programmer.step({4'hc, i[0], 1'b1}, 1'b1);
    check(doe, 1'b0);
    // Strobe far too short: written, but flagged
    i_sotp_programmer.step(6'h38, 1'b0);
    i_sotp_programmer.step(6'h30, 1'b0);
    rd_word;
    check(w, 32'h55555555);
    check(flt, 1'b1);
    i_sotp_programmer.step(6'h30, 1'b0);
    for (i = 2; i < `SOTP_LAST_ADDR; i = i + 1)
      i_sotp_programmer.step(6'h20, 1'b1);
    i_sotp_programmer.step(6'h30, 1'b0);
    check(cso, 1'b1);
    rd_word;
    check(cso, 1'b1);
    i_sotp_programmer.step(6'h10, 1'b1);
    check(cso, 1'b0);
    check(doe, 1'b0);
    // Overflow word to all zeros: reset becomes active low
    i_sotp_programmer.step(6'h20, 1'b1);
    for (i = 0; i < 32; i = i + 1)
      i_sotp_programmer.step(6'h31, 1'b1);
    i_sotp_programmer.step(6'h38, 1'b0);
    i_sotp_programmer.step(6'h30, 1'b0);
    i_sotp_programmer.step(6'h00, 1'b0);
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    check({doe, cso, pm, flt}, 4'h4);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    check(cso, 1'b0);
    report_and_stop;
  end
endmodule // test_serial_otp_program_port
